//--- capture_timer.sv
// Contract
// - Eight channels; each captures when its select bit picks input capture.
// - Channels 4-7 have one capture register; 0-3 add a holding register.
// - Capture empty when read or moved; holding empty when read. Queue mode, no-overwrite set: copy to holding leaves capture full.
// - Valid edge stores main count; no-overwrite clear replaces stored value.
// - Unbuffered with no-overwrite set writes only an empty capture register.
// - Latch/queue select one gives latch mode, zero queue mode.
// - Latch mode copies capture to holding on modulus zero, zero write, force.
// - Latch mode, no-overwrite clear: latch overwrites holding unconditionally.
// - No-overwrite set: hardware writes capture or holding only when empty.
// - Queue mode, no-overwrite clear: old capture moves to holding, then new.
// - Queue mode holding read copies accumulator to its holding, clears it.
// - Four 8-bit accumulators with holding registers count channel edges.
// - Saturate bit stops accumulators at full value instead of wrapping.
// - Each accumulator pair can act as one 16-bit accumulator.
// - Accumulator latch mode moves value to holding and clears on latch events.
// - 16-bit modulus down-counter triggers transfers at zero; usable alone.
// - Modulus counter runs through a 4-bit prescaler.
// - 16-bit main counter, software writable, driven by 7-bit prescaler.
// - Software uses whole 16-bit word accesses for counter and captures.
// - Select bit zero means input capture; one turns capture off for that channel.
`timescale 1ns/1ps
`include "capture_timer_cfg.svh"
`default_nettype none
module capture_timer #(
  parameter int CHANNELS = 8,
  parameter int BUFFERED = 4
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] captureIn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================
  // Elaboration check
  generate
    if (CHANNELS != 8 || BUFFERED != 4) begin : gBadSize
      $error("capture_timer serves exactly 8 channels with 4 buffered");
    end
  endgenerate

  // ==========================================
  // Helpers
  // Merge written bytes into a 16-bit register
  function automatic capture_timer_pkg::word16_t mergeWord(
    input capture_timer_pkg::word16_t old, input logic [31:0] data, input logic [3:0] strb);
    mergeWord = old;
    if (strb[0]) mergeWord[7:0] = data[7:0];
    if (strb[1]) mergeWord[15:8] = data[15:8];
  endfunction

  // Active edge test for one input
  function automatic logic edgeHit(input logic [1:0] mode, input logic prev, input logic now);
    case (capture_timer_pkg::edge_mode_t'(mode))
      capture_timer_pkg::EDGE_RISE: edgeHit = now & ~prev;
      capture_timer_pkg::EDGE_FALL: edgeHit = prev & ~now;
      capture_timer_pkg::EDGE_ANY: edgeHit = now ^ prev;
      default: edgeHit = 1'b0;
    endcase
  endfunction

  // ==========================================
  // Reset release
  logic rstMeta, rstSync;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ==========================================
  // Pin synchronisers and edge history
  logic [7:0] pinMeta, pinNow, pinPrev;
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      pinMeta <= 8'h00;
      pinNow <= 8'h00;
      pinPrev <= 8'h00;
    end else begin
      pinMeta <= captureIn;
      pinNow <= pinMeta;
      pinPrev <= pinNow;
    end
  end

  // ==========================================
  // Control registers
  logic [7:0] chanSelect, noOverwrite;
  logic [15:0] systemCtrl, edgeCtrl, timerCtrl, modCtrl;
  logic latchQueue, saturate, timerEnable, modEnable;
  logic [1:0] pairEnable;
  logic [6:0] timerPrescale;
  logic [3:0] modPrescale;
  assign latchQueue = systemCtrl[`SYS_LATCH_QUEUE_SELECT_BIT];
  assign saturate = systemCtrl[`SYS_SATURATE_BIT];
  assign pairEnable = {systemCtrl[`SYS_PAIR_HI_BIT], systemCtrl[`SYS_PAIR_LO_BIT]};
  assign timerEnable = timerCtrl[`TMR_ENABLE_BIT];
  assign timerPrescale = timerCtrl[`TMR_PRESCALE_LSB +: 7];
  assign modEnable = modCtrl[`MOD_ENABLE_BIT];
  assign modPrescale = modCtrl[`MOD_PRESCALE_LSB +: 4];

  // ==========================================
  // Bus slave, write side
  logic awFull, wFull, doWrite;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  assign doWrite = awFull & wFull & ~s_axi_bvalid;

  // Address and data taken in either order, answered after both
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      awFull <= 1'b0;
      wFull <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awFull <= 1'b1;
        wrAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!awFull && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wFull <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!wFull && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (doWrite) begin
        awFull <= 1'b0;
        wFull <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrAddr <= `OFS_STATUS) ? `RESP_OKAY : `RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Decoded write strobes
  logic wrModCount, wrForce, wrZero;
  assign wrModCount = doWrite && wrAddr == `OFS_MOD_COUNT;
  assign wrForce = doWrite && wrAddr == `OFS_MOD_CTRL && wrStrb[0] && wrData[`MOD_FORCE_BIT];
  assign wrZero = wrModCount && wrStrb[1:0] == 2'b11 && wrData[15:0] == 16'h0000;

  // Configuration writes
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      chanSelect <= 8'h00;
      noOverwrite <= 8'h00;
      systemCtrl <= `RESET_CTRL;
      edgeCtrl <= `RESET_EDGE;
      timerCtrl <= `RESET_CTRL;
      modCtrl <= `RESET_CTRL;
    end else if (doWrite) begin
      case (wrAddr)
        `OFS_CHAN_SELECT: if (wrStrb[0]) chanSelect <= wrData[7:0];
        `OFS_NO_OVERWRITE: if (wrStrb[0]) noOverwrite <= wrData[7:0];
        `OFS_SYSTEM_CTRL: systemCtrl <= mergeWord(systemCtrl, wrData, wrStrb);
        `OFS_EDGE_CTRL: edgeCtrl <= mergeWord(edgeCtrl, wrData, wrStrb);
        `OFS_TIMER_CTRL: timerCtrl <= mergeWord(timerCtrl, wrData, wrStrb);
        // Force bit is a one-shot and is never stored
        `OFS_MOD_CTRL: begin
          modCtrl <= mergeWord(modCtrl, wrData, wrStrb);
          modCtrl[`MOD_FORCE_BIT] <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // Main counter with 7-bit prescaler
  logic [6:0] timerDiv;
  logic [15:0] timerCount;
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      timerDiv <= 7'h00;
      timerCount <= 16'h0000;
    end else begin
      if (doWrite && wrAddr == `OFS_TIMER_COUNT) begin
        timerCount <= mergeWord(timerCount, wrData, wrStrb);
      end else if (timerEnable && timerDiv == timerPrescale) begin
        timerCount <= timerCount + 16'h0001;
      end
      if (!timerEnable || timerDiv == timerPrescale) timerDiv <= 7'h00;
      else timerDiv <= timerDiv + 7'h01;
    end
  end

  // ==========================================
  // Modulus down-counter with 4-bit prescaler
  logic [3:0] modDiv;
  logic [15:0] modCount, modReload;
  logic modTick, modZero, zeroFlag, latchEvent;
  assign modTick = modEnable && modDiv == modPrescale;
  assign modZero = modTick && modCount == 16'h0001;
  // Transfer triggers: zero count, zero write, force
  assign latchEvent = (modZero && modCtrl[`MOD_LATCH_BIT]) || wrZero || wrForce;

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      modDiv <= 4'h0;
      modCount <= 16'h0000;
      modReload <= 16'h0000;
    end else begin
      if (!modEnable || modTick) modDiv <= 4'h0;
      else modDiv <= modDiv + 4'h1;
      if (wrModCount) begin
        modReload <= mergeWord(modReload, wrData, wrStrb);
        modCount <= mergeWord(modCount, wrData, wrStrb);
      end else if (modZero) begin
        modCount <= modCtrl[`MOD_PERIODIC_BIT] ? modReload : 16'h0000;
      end else if (modTick && modCount != 16'h0000) begin
        modCount <= modCount - 16'h0001;
      end
    end
  end

  // Sticky zero flag for time-base use, one to clear, set wins
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) zeroFlag <= 1'b0;
    else if (modZero) zeroFlag <= 1'b1;
    else if (doWrite && wrAddr == `OFS_STATUS && wrStrb[0] && wrData[`STATUS_ZERO_BIT])
      zeroFlag <= 1'b0;
  end

  // ==========================================
  // Bus slave, read side
  logic rdTake;
  logic [7:0] rdAddr;
  assign rdTake = s_axi_arvalid & s_axi_arready;
  assign rdAddr = s_axi_araddr;

  // ==========================================
  // Capture, holding and accumulator storage
  logic [15:0] capture [8];
  logic [15:0] hold [4];
  logic [7:0] acc [4];
  logic [7:0] accHold [4];
  logic [7:0] capFull;
  logic [3:0] holdFull;
  logic [15:0] next_capture [8];
  logic [15:0] next_hold [4];
  logic [7:0] next_acc [4];
  logic [7:0] next_accHold [4];
  logic [7:0] next_capFull;
  logic [3:0] next_holdFull;
  logic [7:0] edges;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      edges[i] = edgeHit(edgeCtrl[2*i +: 2], pinPrev[i], pinNow[i]);
    end
  end

  // Next state: reads empty first, then latches, captures and counts win
  always_comb begin
    logic [16:0] wide;
    wide = 17'h00000;
    next_capFull = capFull;
    next_holdFull = holdFull;
    for (int i = 0; i < 8; i++) next_capture[i] = capture[i];
    for (int i = 0; i < 4; i++) begin
      next_hold[i] = hold[i];
      next_acc[i] = acc[i];
      next_accHold[i] = accHold[i];
    end
    // Read side effects
    if (rdTake) begin
      if (rdAddr[7:5] == `OFS_CAPTURE_BASE) next_capFull[rdAddr[4:2]] = 1'b0;
      if (rdAddr[7:4] == `OFS_HOLD_BASE) begin
        next_holdFull[rdAddr[3:2]] = 1'b0;
        if (!latchQueue) begin
          next_accHold[rdAddr[3:2]] = acc[rdAddr[3:2]];
          next_acc[rdAddr[3:2]] = 8'h00;
        end
      end
    end
    // Latch mode transfers
    if (latchEvent && latchQueue) begin
      for (int i = 0; i < 4; i++) begin
        if (!noOverwrite[i] || !next_holdFull[i]) begin
          next_hold[i] = capture[i];
          next_holdFull[i] = 1'b1;
          next_capFull[i] = 1'b0;
        end
        next_accHold[i] = acc[i];
        next_acc[i] = 8'h00;
      end
    end
    // Captures on valid edges of input-capture channels
    for (int i = 0; i < 8; i++) begin
      if (edges[i] && !chanSelect[i]) begin
        if (i < 4 && !latchQueue) begin
          if (!noOverwrite[i]) begin
            next_hold[i] = next_capture[i];
            next_holdFull[i] = next_capFull[i];
            next_capture[i] = timerCount;
            next_capFull[i] = 1'b1;
          end else if (!next_capFull[i]) begin
            next_capture[i] = timerCount;
            next_capFull[i] = 1'b1;
          end else if (!next_holdFull[i]) begin
            next_hold[i] = next_capture[i];
            next_holdFull[i] = 1'b1;
          end
        end else if (!noOverwrite[i] || !next_capFull[i]) begin
          next_capture[i] = timerCount;
          next_capFull[i] = 1'b1;
        end
      end
    end
    // Accumulators count edges on channels 0-3, paired 1/0 and 3/2
    for (int p = 0; p < 2; p++) begin
      if (pairEnable[p]) begin
        if (edges[2*p+1]) begin
          wide = {1'b0, next_acc[2*p+1], next_acc[2*p]} + 17'h00001;
          if (!(saturate && wide[16])) begin
            next_acc[2*p+1] = wide[15:8];
            next_acc[2*p] = wide[7:0];
          end
        end
      end else begin
        for (int k = 0; k < 2; k++) begin
          if (edges[2*p+k] && !(saturate && next_acc[2*p+k] == 8'hff))
            next_acc[2*p+k] = next_acc[2*p+k] + 8'h01;
        end
      end
    end
  end

  // Storage registers
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      capFull <= 8'h00;
      holdFull <= 4'h0;
      for (int i = 0; i < 8; i++) capture[i] <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        hold[i] <= 16'h0000;
        acc[i] <= 8'h00;
        accHold[i] <= 8'h00;
      end
    end else begin
      capFull <= next_capFull;
      holdFull <= next_holdFull;
      for (int i = 0; i < 8; i++) capture[i] <= next_capture[i];
      for (int i = 0; i < 4; i++) begin
        hold[i] <= next_hold[i];
        acc[i] <= next_acc[i];
        accHold[i] <= next_accHold[i];
      end
    end
  end

  // ==========================================
  // Read data selection
  logic [31:0] readData;
  logic readHit;
  always_comb begin
    readData = 32'h0000_0000;
    readHit = 1'b1;
    case (rdAddr)
      `OFS_CHAN_SELECT: readData[7:0] = chanSelect;
      `OFS_NO_OVERWRITE: readData[7:0] = noOverwrite;
      `OFS_SYSTEM_CTRL: readData[15:0] = systemCtrl;
      `OFS_EDGE_CTRL: readData[15:0] = edgeCtrl;
      `OFS_TIMER_CTRL: readData[15:0] = timerCtrl;
      `OFS_TIMER_COUNT: readData[15:0] = timerCount;
      `OFS_MOD_CTRL: readData[15:0] = modCtrl;
      `OFS_MOD_COUNT: readData[15:0] = modCount;
      `OFS_STATUS: readData = {16'h0000, capFull, holdFull, 3'h0, zeroFlag};
      default: begin
        if (rdAddr[1:0] != 2'b00) readHit = 1'b0;
        else if (rdAddr[7:5] == `OFS_CAPTURE_BASE) readData[15:0] = capture[rdAddr[4:2]];
        else if (rdAddr[7:4] == `OFS_HOLD_BASE) readData[15:0] = hold[rdAddr[3:2]];
        else if (rdAddr[7:4] == `OFS_ACC_BASE) readData[7:0] = acc[rdAddr[3:2]];
        else if (rdAddr[7:4] == `OFS_ACC_HOLD_BASE) readData[7:0] = accHold[rdAddr[3:2]];
        else readHit = 1'b0;
      end
    endcase
  end

  // One read at a time, data registered
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (rdTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readData;
        s_axi_rresp <= readHit ? `RESP_OKAY : `RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

//--- capture_timer_cfg.svh
`ifndef CAPTURE_TIMER_CFG_SVH
`define CAPTURE_TIMER_CFG_SVH
// ==========================================
// Register byte offsets
`define OFS_CHAN_SELECT 8'h00
`define OFS_NO_OVERWRITE 8'h04
`define OFS_SYSTEM_CTRL 8'h08
`define OFS_EDGE_CTRL 8'h0c
`define OFS_TIMER_CTRL 8'h10
`define OFS_TIMER_COUNT 8'h14
`define OFS_MOD_CTRL 8'h18
`define OFS_MOD_COUNT 8'h1c
`define OFS_STATUS 8'h20
`define OFS_CAPTURE_BASE 3'h2
`define OFS_HOLD_BASE 4'h6
`define OFS_ACC_BASE 4'h7
`define OFS_ACC_HOLD_BASE 4'h8
// ==========================================
// Field positions
`define SYS_LATCH_QUEUE_SELECT_BIT 0
`define SYS_SATURATE_BIT 1
`define SYS_PAIR_LO_BIT 2
`define SYS_PAIR_HI_BIT 3
`define TMR_ENABLE_BIT 0
`define TMR_PRESCALE_LSB 8
`define MOD_ENABLE_BIT 0
`define MOD_PERIODIC_BIT 1
`define MOD_LATCH_BIT 2
`define MOD_FORCE_BIT 3
`define MOD_PRESCALE_LSB 8
`define STATUS_ZERO_BIT 0
// ==========================================
// Reset values and answers
`define RESET_CTRL 16'h0000
`define RESET_EDGE 16'h5555
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11
`endif

//--- capture_timer_pkg.sv
`default_nettype none
package capture_timer_pkg;
  // Edge selection for one capture input
  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_ANY} edge_mode_t;
  typedef logic [15:0] word16_t;
  typedef logic [7:0] byte8_t;
endpackage
`default_nettype wire

//--- capture_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module capture_timer_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] captureIn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Bus steps
  sequence readTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence writeTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // ==========================================
  // Register access timing and answers
  AST_READ_ANSWER: assert property (readTake |=> s_axi_rvalid)
    else $error("read answer late");
  AST_READ_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  AST_READ_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while pending");
  AST_READ_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_READ_DECERR: assert property (readTake ##0 (s_axi_araddr > 8'h8c)
    |=> s_axi_rresp == 2'b11 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  AST_WRITE_ANSWER: assert property (writeTake |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_WRITE_DECERR: assert property (writeTake ##0 (s_axi_awaddr > 8'h20)
    |-> ##2 s_axi_bresp == 2'b11) else $error("unmapped write accepted");
  AST_WRITE_BUSY: assert property (writeTake |=> !s_axi_awready [*2])
    else $error("write taken while busy");
endmodule
`default_nettype wire

//--- edge_source.sv
`timescale 1ns/1ps
`default_nettype none
module edge_source (
  input wire logic core_clk,
  output logic [7:0] pins
);
  initial pins = 8'h00;
  // Rising then falling level on one pin, n times
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge core_clk);
      pins[ch] <= 1'b1;
      repeat (4) @(posedge core_clk);
      pins[ch] <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- tb_capture_timer.sv
`timescale 1ns/1ps
`include "capture_timer_cfg.svh"
`default_nettype none
module tb_capture_timer;
  localparam logic [1:0] OK = `RESP_OKAY;
  localparam logic [1:0] DE = `RESP_DECERR;
  logic core_clk, reset_n;
  logic [7:0] captureIn, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int num_errors = 0;
  int samples_checked = 0;
  capture_timer i_capture_timer (.core_clk(core_clk), .reset_n(reset_n), .captureIn(captureIn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  edge_source i_edge_source (.core_clk(core_clk), .pins(captureIn));
  // ==========================================
  // Clock and run limit
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    timeout();
  end
  // ==========================================
  // Reporting
  task automatic print_verdict();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    num_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic timeout();
    fail("wait limit used up");
    print_verdict();
  endtask
  task automatic check_data(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) fail($sformatf("data %h, expected %h", g, e));
  endtask
  task automatic check_resp(input logic [1:0] e, input logic [1:0] g);
    samples_checked++;
    if (g !== e) fail($sformatf("response %b, expected %b", g, e));
  endtask
  // ==========================================
  // Bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    s_axi_bready <= 1'b0;
    if (n >= 100) timeout();
    check_resp(er, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    s_axi_rready <= 1'b0;
    if (n >= 100) timeout();
    check_resp(er, s_axi_rresp);
    check_data(ed, s_axi_rdata);
  endtask
  // ==========================================
  // Scenarios
  task automatic reset_map();
    rd(8'h0c, 32'h5555, OK);
    rd(8'h00, 32'h0, OK);
    rd(8'h90, 32'h0, DE);
    wr(8'h24, 32'h1, DE);
  endtask
  task automatic single_capture();
    wr(8'h14, 32'h1234, OK);
    i_edge_source.pulse(4, 1);
    rd(8'h50, 32'h1234, OK);
    wr(8'h14, 32'h2222, OK);
    i_edge_source.pulse(4, 1);
    wr(8'h14, 32'h3333, OK);
    i_edge_source.pulse(4, 1);
    rd(8'h50, 32'h3333, OK);
    wr(8'h04, 32'h10, OK);
    wr(8'h14, 32'h4444, OK);
    i_edge_source.pulse(4, 1);
    wr(8'h14, 32'h5555, OK);
    i_edge_source.pulse(4, 1);
    rd(8'h50, 32'h4444, OK);
    wr(8'h04, 32'h0, OK);
    wr(8'h00, 32'h20, OK);
    wr(8'h14, 32'h6666, OK);
    i_edge_source.pulse(5, 1);
    rd(8'h20, 32'h0, OK);
    wr(8'h00, 32'h0, OK);
    i_edge_source.pulse(5, 1);
    rd(8'h54, 32'h6666, OK);
  endtask
  task automatic queue_mode();
    wr(8'h14, 32'h0100, OK);
    i_edge_source.pulse(0, 1);
    wr(8'h14, 32'h0200, OK);
    i_edge_source.pulse(0, 1);
    rd(8'h20, 32'h0110, OK);
    rd(8'h40, 32'h0200, OK);
    rd(8'h60, 32'h0100, OK);
    rd(8'h80, 32'h2, OK);
    rd(8'h70, 32'h0, OK);
    rd(8'h20, 32'h0, OK);
  endtask
  task automatic latch_mode();
    wr(8'h08, 32'h1, OK);
    wr(8'h14, 32'h0300, OK);
    i_edge_source.pulse(1, 1);
    wr(8'h18, 32'h8, OK);
    rd(8'h64, 32'h0300, OK);
    rd(8'h84, 32'h1, OK);
    rd(8'h74, 32'h0, OK);
    wr(8'h14, 32'h0400, OK);
    i_edge_source.pulse(1, 1);
    wr(8'h14, 32'h0500, OK);
    i_edge_source.pulse(1, 1);
    wr(8'h1c, 32'h0, OK);
    rd(8'h64, 32'h0500, OK);
    rd(8'h84, 32'h2, OK);
    wr(8'h04, 32'h2, OK);
    wr(8'h14, 32'h0700, OK);
    i_edge_source.pulse(1, 1);
    wr(8'h18, 32'h8, OK);
    wr(8'h14, 32'h0800, OK);
    i_edge_source.pulse(1, 1);
    wr(8'h18, 32'h8, OK);
    rd(8'h64, 32'h0700, OK);
    wr(8'h04, 32'h0, OK);
  endtask
  task automatic modulus_zero();
    wr(8'h14, 32'h0900, OK);
    i_edge_source.pulse(2, 1);
    wr(8'h1c, 32'h3, OK);
    wr(8'h18, 32'h0f05, OK);
    repeat (20) @(posedge core_clk);
    rd(8'h68, 32'h0, OK);
    repeat (60) @(posedge core_clk);
    rd(8'h68, 32'h0900, OK);
    rd(8'h88, 32'h1, OK);
    rd(8'h20, 32'h00b1, OK);
    wr(8'h20, 32'h1, OK);
    rd(8'h20, 32'h00b0, OK);
    wr(8'h18, 32'h0, OK);
  endtask
  // Main count through the widest prescale
  task automatic timer_prescale();
    wr(8'h14, 32'h0, OK);
    wr(8'h10, 32'h7f01, OK);
    repeat (300) @(posedge core_clk);
    wr(8'h10, 32'h0, OK);
    rd(8'h14, 32'h2, OK);
  endtask
  task automatic accumulators();
    wr(8'h08, 32'h3, OK);
    wr(8'h18, 32'h8, OK);
    i_edge_source.pulse(3, 260);
    rd(8'h7c, 32'hff, OK);
    wr(8'h08, 32'h5, OK);
    wr(8'h18, 32'h8, OK);
    i_edge_source.pulse(1, 258);
    rd(8'h70, 32'h2, OK);
    rd(8'h74, 32'h1, OK);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    reset_map();
    single_capture();
    queue_mode();
    latch_mode();
    modulus_zero();
    accumulators();
    timer_prescale();
    print_verdict();
  end
endmodule
bind capture_timer capture_timer_checker i_capture_timer_checker (.core_clk(core_clk),
  .reset_n(reset_n), .captureIn(captureIn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire
